// ### pkg/fault_mon_pkg.sv
/*
  Constants for the communications fault monitor: register map, status
  bit positions, command codes and timing counts.
  Assumes a 250 MHz core clock and a 32-bit APB register bus.
*/
package fault_mon_pkg;
  // ----------------------------------------------------------------------
  // Register space
  // ----------------------------------------------------------------------
  localparam int REG_W = 16;
  localparam int ADDR_W = 9;
  localparam int PAGE_W = 3;
  localparam int IDX_W = ADDR_W - PAGE_W;
  localparam logic [2:0] PAGE_CTRL = 3'h0;
  localparam logic [2:0] PAGE_MEAS = 3'h1;
  localparam logic [2:0] PAGE_CFG = 3'h2;
  localparam logic [2:0] PAGE_CMD = 3'h3;
  localparam logic [2:0] PAGE_RSVD = 3'h4;
  localparam logic [5:0] IDX_STATUS = 6'h00;
  localparam logic [5:0] IDX_SCAN_COUNT = 6'h01;
  localparam logic [5:0] IDX_WDOG_PERIOD = 6'h02;
  localparam logic [5:0] IDX_CSUM_STORED = 6'h03;
  localparam int MEAS_REGS = 16;
  localparam logic [15:0] WDOG_PERIOD_RESET = 16'h0010;
  // ----------------------------------------------------------------------
  // Status register bits
  // ----------------------------------------------------------------------
  localparam int ST_CRC = 0;
  localparam int ST_COMMS_FAIL = 1;
  localparam int ST_BUF_FAULT = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_UNDERRUN = 4;
  localparam int ST_WDOG = 5;
  localparam int ST_CSUM = 6;
  localparam int ST_BUSY = 7;
  localparam int ST_SLEEP = 8;
  localparam int ST_FLAGS = 7;
  // ----------------------------------------------------------------------
  // Command codes, written as the index of a page 3 register
  // ----------------------------------------------------------------------
  localparam logic [5:0] CMD_SCAN_VOLT = 6'h01;
  localparam logic [5:0] CMD_SCAN_TEMP = 6'h02;
  localparam logic [5:0] CMD_MEASURE = 6'h03;
  localparam logic [5:0] CMD_SCAN_MUX = 6'h04;
  localparam logic [5:0] CMD_CALC_CSUM = 6'h05;
  localparam logic [5:0] CMD_CHECK_CSUM = 6'h06;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int REPLY_TIMEOUT_NS = 2000;
  localparam int REPLY_TIMEOUT_CYC = (REPLY_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
  localparam int WDOG_TICK_NS = 1000;
  localparam int WDOG_TICK_CYC = (WDOG_TICK_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [15:0] MISR_POLY = 16'h8016;
endpackage : fault_mon_pkg

// ### verilog/fault_misr.sv
/*
  Multiple-input shift register that folds a stream of words into one
  signature. Assumes the caller clears it before each pass.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_misr #(
  parameter int W = 16,
  parameter logic [15:0] POLY = 16'h8016
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic shift_en,
  input wire logic [W-1:0] din,
  output logic [W-1:0] sig
);
  // Clear has priority so a new pass never inherits the old signature.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sig <= '0;
    end else if (clear) begin
      sig <= '0;
    end else if (shift_en) begin
      sig <= ({sig[W-2:0], 1'b0} ^ (sig[W-1] ? POLY[W-1:0] : '0)) ^ din;
    end
  end
endmodule : fault_misr
`default_nettype wire

// ### verilog/fault_fifo.sv
/*
  Communications FIFO between the host serial side and the chain side.
  Each entry carries a parity bit checked on the way out. Assumes push and
  pop are single-cycle strobes on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic pop,
  output logic [W-1:0] pop_data,
  output logic pop_valid,
  output logic overrun,
  output logic underrun,
  output logic parity_err
);
  localparam int AW = $clog2(DEPTH);
  logic [W:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [AW:0] count_reg;
  logic full, empty, do_push, do_pop;

  assign full = (count_reg == (AW+1)'(DEPTH));
  assign empty = (count_reg == '0);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  // A push into a full buffer is dropped so stored entries survive.
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= {^push_data, push_data};
    end
  end

  // Pointers and fill level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) wr_ptr_reg <= AW'((wr_ptr_reg + 1'b1) % DEPTH);
      if (do_pop) rd_ptr_reg <= AW'((rd_ptr_reg + 1'b1) % DEPTH);
      count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // Output word and one-cycle fault strobes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pop_data <= '0;
      pop_valid <= 1'b0;
      overrun <= 1'b0;
      underrun <= 1'b0;
      parity_err <= 1'b0;
    end else begin
      pop_valid <= do_pop;
      overrun <= push && full;
      underrun <= pop && empty;
      parity_err <= do_pop && (^mem_reg[rd_ptr_reg]);
      if (do_pop) pop_data <= mem_reg[rd_ptr_reg][W-1:0];
    end
  end
endmodule : fault_fifo
`default_nettype wire

// ### verilog/comms_fault_monitor.sv
/*
  Communications fault supervision and paged register space of a stacked
  battery monitor: CRC fault response, chain reply timeout, scan counters,
  FIFO fault flags, communications watchdog and the page 2 checksum.
  Assumes a serial front end on the core clock that presents decoded
  commands with a CRC verdict, a sampled chain clock pin and an APB master.
*/
// Contract
// RQ1: Bad CRC gets NAK and error flag. The code gives neither while asleep or in the cycle of a page 3 APB write.
// RQ2: Missing chain reply gives comms-failure response.
// RQ3: Host treats missing reply as failure.
// RQ4: Voltage scan increments measurement counter.
// RQ5: Temperature, measure, mux scans increment diagnostic counter.
// RQ6: FIFO parity failure sets buffer fault.
// RQ7: Push into full FIFO sets overrun.
// RQ8: Chain pop from empty FIFO sets underrun.
// RQ9: Valid command restarts watchdog; expiry sets flag.
// RQ10: Expiry sleeps, stops scans, keeps flag.
// RQ11: Host tests watchdog with shortest period.
// RQ12: Registers are 16 bits, 9-bit address.
// RQ13: Upper three address bits select page.
// RQ14: Page 1 measurements, page 3 commands.
// RQ15: Pages 1,3 outside checksum; 4-7 reserved.
// RQ16: Calculate command signs all page 2.
// RQ17: Check command recomputes and flags mismatch.
// RQ18: Host ignores reserved bits, writes zero.
// RQ19: Host recalculates checksum after page 2 change.
// RQ20: Counters wrap; flags stay until cleared.
`timescale 1ns/1ps
`default_nettype none
module comms_fault_monitor
  import fault_mon_pkg::*;
#(
  parameter int CFG_REGS = 8,
  parameter int FIFO_DEPTH = 8,
  parameter int WDOG_TICK = fault_mon_pkg::WDOG_TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [10:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_code,
  input wire logic cmd_crc_ok,
  output logic nak,
  input wire logic fwd_start,
  input wire logic chain_reply,
  output logic comms_fail,
  input wire logic spi_byte_valid,
  input wire logic [7:0] spi_byte,
  input wire logic chain_clk,
  output logic [7:0] chain_data,
  output logic chain_data_valid,
  input wire logic meas_wr,
  input wire logic [3:0] meas_idx,
  input wire logic [15:0] meas_data,
  input wire logic wake,
  output logic sleep,
  output logic scan_enable
);
  import fault_mon_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {CS_IDLE = 2'b00, CS_RUN = 2'b01,
    CS_DONE = 2'b11} csum_state_e;
  localparam int CW = $clog2(CFG_REGS);
  csum_state_e cs_state_reg;
  logic cs_check_reg;
  logic [CW-1:0] cs_idx_reg;
  logic [REG_W-1:0] cfg_reg [CFG_REGS];
  logic [REG_W-1:0] meas_reg [MEAS_REGS];
  logic [REG_W-1:0] csum_stored_reg, wdog_period_reg, sig;
  logic [7:0] meas_cnt_reg, diag_cnt_reg;
  logic [ST_FLAGS-1:0] flags_reg, flag_set, flag_clr;
  logic [1:0] cclk_sync_reg, wake_sync_reg;
  logic cclk_prev_reg;
  logic chain_pop, ff_over, ff_under, ff_par;
  logic [15:0] reply_cnt_reg;
  logic reply_wait_reg;
  logic [31:0] wdog_cnt_reg;
  logic [31:0] wdog_limit;
  logic wdog_expire;
  logic [ADDR_W-1:0] reg_addr;
  logic [PAGE_W-1:0] page;
  logic [IDX_W-1:0] idx;
  logic bus_setup, bus_access, bus_wr, mapped;
  logic apb_cmd, good_cmd, any_cmd;
  logic [5:0] code;
  logic [REG_W-1:0] rd_val;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Each 16-bit register sits in the low half of an aligned word.
  assign reg_addr = paddr[10:2]; // RQ12
  assign page = reg_addr[8:6]; // RQ13
  assign idx = reg_addr[5:0]; // RQ13
  assign bus_setup = psel && !penable;
  assign bus_access = psel && penable && pready;
  assign bus_wr = bus_access && pwrite && !pslverr;

  // Reserved pages and holes answer with an error and no side effect.
  always_comb begin
    mapped = 1'b0;
    rd_val = '0;
    unique case (page)
      PAGE_CTRL: begin
        mapped = (idx <= IDX_CSUM_STORED);
        if (idx == IDX_STATUS) begin
          rd_val = REG_W'({sleep, cs_state_reg != CS_IDLE, flags_reg});
        end else if (idx == IDX_SCAN_COUNT) begin
          rd_val = {diag_cnt_reg, meas_cnt_reg};
        end else if (idx == IDX_WDOG_PERIOD) begin
          rd_val = wdog_period_reg;
        end else if (idx == IDX_CSUM_STORED) begin
          rd_val = csum_stored_reg;
        end
      end
      PAGE_MEAS: begin
        mapped = (idx < IDX_W'(MEAS_REGS)); // RQ14
        if (mapped) rd_val = meas_reg[idx[3:0]];
      end
      PAGE_CFG: begin
        mapped = (idx < IDX_W'(CFG_REGS));
        if (mapped) rd_val = cfg_reg[idx[CW-1:0]];
      end
      PAGE_CMD: mapped = pwrite; // RQ14
      default: mapped = 1'b0; // RQ15
    endcase
  end

  // Zero-wait answer: ready rises in the first access cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= bus_setup;
      if (bus_setup) begin
        pslverr <= !mapped;
        prdata <= {16'h0000, (pwrite ? 16'h0000 : rd_val)};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------------
  // A page 3 write came over a checked bus, so it counts as correct.
  assign apb_cmd = bus_wr && (page == PAGE_CMD);
  assign code = apb_cmd ? idx : cmd_code;
  assign good_cmd = !sleep && (apb_cmd || (cmd_valid && cmd_crc_ok));
  assign any_cmd = apb_cmd || cmd_valid;

  // The NAK strobe answers the cycle after a CRC failure.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nak <= 1'b0;
    end else begin
      nak <= cmd_valid && !cmd_crc_ok && !sleep && !apb_cmd; // RQ1
    end
  end

  // Reply-less scans are confirmed through free-running counters.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_cnt_reg <= '0;
      diag_cnt_reg <= '0;
    end else if (good_cmd) begin
      if (code == CMD_SCAN_VOLT) begin
        meas_cnt_reg <= meas_cnt_reg + 8'h01; // RQ4 RQ20
      end
      if (code == CMD_SCAN_TEMP || code == CMD_MEASURE ||
          code == CMD_SCAN_MUX) begin
        diag_cnt_reg <= diag_cnt_reg + 8'h01; // RQ5 RQ20
      end
    end
  end

  // ----------------------------------------------------------------------
  // Chain reply timeout
  // ----------------------------------------------------------------------
  // A reply in the last counted cycle still wins over the timeout.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reply_wait_reg <= 1'b0;
      reply_cnt_reg <= '0;
      comms_fail <= 1'b0;
    end else begin
      comms_fail <= 1'b0;
      if (fwd_start) begin
        reply_wait_reg <= 1'b1;
        reply_cnt_reg <= '0;
      end else if (reply_wait_reg) begin
        if (chain_reply) begin
          reply_wait_reg <= 1'b0;
        end else if (reply_cnt_reg == 16'(REPLY_TIMEOUT_CYC - 1)) begin
          reply_wait_reg <= 1'b0;
          comms_fail <= 1'b1; // RQ2
        end else begin
          reply_cnt_reg <= reply_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Chain clock sampling and FIFO
  // ----------------------------------------------------------------------
  // Two stages for the pin, then a third flop for the edge detector.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cclk_sync_reg <= '0;
      cclk_prev_reg <= 1'b0;
      wake_sync_reg <= '0;
    end else begin
      cclk_sync_reg <= {cclk_sync_reg[0], chain_clk};
      cclk_prev_reg <= cclk_sync_reg[1];
      wake_sync_reg <= {wake_sync_reg[0], wake};
    end
  end
  assign chain_pop = cclk_sync_reg[1] && !cclk_prev_reg;

  fault_fifo #(
    .W(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .push(spi_byte_valid),
    .push_data(spi_byte),
    .pop(chain_pop),
    .pop_data(chain_data),
    .pop_valid(chain_data_valid),
    .overrun(ff_over), // RQ7
    .underrun(ff_under), // RQ8
    .parity_err(ff_par) // RQ6
  );

  // ----------------------------------------------------------------------
  // Watchdog and sleep
  // ----------------------------------------------------------------------
  // Period is in ticks; zero disables so bring-up can run without it.
  assign wdog_limit = 32'(wdog_period_reg) * 32'(WDOG_TICK);
  assign wdog_expire = !sleep && (wdog_period_reg != '0) &&
    (wdog_cnt_reg >= wdog_limit - 32'd1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_cnt_reg <= '0;
    end else if (good_cmd || sleep) begin
      wdog_cnt_reg <= '0; // RQ9
    end else if (wdog_expire) begin
      wdog_cnt_reg <= '0;
    end else begin
      wdog_cnt_reg <= wdog_cnt_reg + 32'd1;
    end
  end

  // Sleep stops scans until the wake pin is seen.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep <= 1'b0;
      scan_enable <= 1'b1;
    end else if (wdog_expire) begin
      sleep <= 1'b1; // RQ10
      scan_enable <= 1'b0; // RQ10
    end else if (sleep && wake_sync_reg[1]) begin
      sleep <= 1'b0;
      scan_enable <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Sticky flags, write one to clear, set wins over clear
  // ----------------------------------------------------------------------
  always_comb begin
    flag_set = '0;
    flag_set[ST_CRC] = cmd_valid && !cmd_crc_ok && !sleep && !apb_cmd;
    flag_set[ST_COMMS_FAIL] = reply_wait_reg && !fwd_start &&
      !chain_reply && reply_cnt_reg == 16'(REPLY_TIMEOUT_CYC - 1);
    flag_set[ST_BUF_FAULT] = ff_par; // RQ6
    flag_set[ST_OVERRUN] = ff_over;
    flag_set[ST_UNDERRUN] = ff_under;
    flag_set[ST_WDOG] = wdog_expire;
    flag_set[ST_CSUM] = (cs_state_reg == CS_DONE) && cs_check_reg &&
      (sig != csum_stored_reg); // RQ17
  end
  assign flag_clr = (bus_wr && page == PAGE_CTRL && idx == IDX_STATUS) ?
    pwdata[ST_FLAGS-1:0] : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~flag_clr) | flag_set; // RQ20 RQ1 RQ9
    end
  end

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_period_reg <= WDOG_PERIOD_RESET;
      for (int i = 0; i < CFG_REGS; i++) cfg_reg[i] <= '0;
      for (int i = 0; i < MEAS_REGS; i++) meas_reg[i] <= '0;
    end else begin
      if (bus_wr && page == PAGE_CTRL && idx == IDX_WDOG_PERIOD) begin
        wdog_period_reg <= pwdata[15:0];
      end
      if (bus_wr && page == PAGE_CFG) begin
        cfg_reg[idx[CW-1:0]] <= pwdata[15:0];
      end
      if (meas_wr) meas_reg[meas_idx] <= meas_data; // RQ14
    end
  end

  // ----------------------------------------------------------------------
  // Page 2 checksum
  // ----------------------------------------------------------------------
  // Only page 2 feeds the signature; measurements and commands change
  // constantly and would make the checksum useless.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_state_reg <= CS_IDLE;
      cs_check_reg <= 1'b0;
      cs_idx_reg <= '0;
      csum_stored_reg <= '0;
    end else begin
      unique case (cs_state_reg)
        CS_IDLE: begin
          if (good_cmd && (code == CMD_CALC_CSUM ||
              code == CMD_CHECK_CSUM)) begin
            cs_state_reg <= CS_RUN;
            cs_check_reg <= (code == CMD_CHECK_CSUM);
            cs_idx_reg <= '0;
          end
        end
        CS_RUN: begin
          if (cs_idx_reg == CW'(CFG_REGS - 1)) begin
            cs_state_reg <= CS_DONE;
          end else begin
            cs_idx_reg <= cs_idx_reg + 1'b1;
          end
        end
        CS_DONE: begin
          if (!cs_check_reg) csum_stored_reg <= sig; // RQ16
          cs_state_reg <= CS_IDLE; // RQ17
        end
        default: cs_state_reg <= CS_IDLE;
      endcase
    end
  end

  fault_misr #(
    .W(REG_W),
    .POLY(MISR_POLY)
  ) u_misr (
    .clk(clk),
    .rst_n(rst_n),
    .clear(cs_state_reg == CS_IDLE),
    .shift_en(cs_state_reg == CS_RUN), // RQ15
    .din(cfg_reg[cs_idx_reg]),
    .sig(sig)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_nak_on_crc: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && !cmd_crc_ok && !sleep && !apb_cmd |=> nak && flags_reg[ST_CRC]) // RQ1
    else $error("bad CRC not answered with NAK");
  a_reply_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    fwd_start ##1 (!chain_reply && !fwd_start)[*8] |-> !comms_fail) // RQ2
    else $error("comms failure raised too early");
  a_meas_count: assert property (@(posedge clk) disable iff (!rst_n)
    good_cmd && code == CMD_SCAN_VOLT |=>
      meas_cnt_reg == $past(meas_cnt_reg) + 8'h01) // RQ4
    else $error("measurement counter did not advance");
  a_diag_count: assert property (@(posedge clk) disable iff (!rst_n)
    good_cmd && code == CMD_MEASURE |=>
      diag_cnt_reg == $past(diag_cnt_reg) + 8'h01) // RQ5
    else $error("diagnostic counter did not advance");
  a_overrun_flag: assert property (@(posedge clk) disable iff (!rst_n)
    ff_over |=> flags_reg[ST_OVERRUN]) // RQ7
    else $error("overrun not flagged");
  a_underrun_flag: assert property (@(posedge clk) disable iff (!rst_n)
    ff_under |=> flags_reg[ST_UNDERRUN]) // RQ8
    else $error("underrun not flagged");
  a_wdog_sleep: assert property (@(posedge clk) disable iff (!rst_n)
    wdog_expire |=> sleep && !scan_enable && flags_reg[ST_WDOG]) // RQ10
    else $error("watchdog expiry did not sleep");
  a_rsvd_page: assert property (@(posedge clk) disable iff (!rst_n)
    bus_setup && paddr[10] |=> pslverr && pready) // RQ15
    else $error("reserved page not refused");
  a_csum_walk: assert property (@(posedge clk) disable iff (!rst_n)
    cs_state_reg == CS_IDLE ##1 cs_state_reg == CS_RUN |->
      ##(CFG_REGS) cs_state_reg == CS_DONE) // RQ16
    else $error("checksum pass length wrong");
  a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    flags_reg[ST_WDOG] && flag_clr[ST_WDOG] == 1'b0 |=> flags_reg[ST_WDOG]) // RQ20
    else $error("fault flag dropped without clear");
endmodule : comms_fault_monitor
`default_nettype wire

// ### sim/chain_partner.sv
/*
  Chain-side model: clocks bytes out of the monitor in bursts.
  Assumes the bench sets n before it raises go for one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module chain_partner (
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] n,
  input wire logic [7:0] chain_data,
  input wire logic chain_data_valid,
  output logic chain_clk,
  output logic [7:0] last_byte,
  output logic [7:0] n_seen
);
  // The link clock stands low outside a burst, as a real chain does.
  initial begin
    chain_clk = 1'b0;
    forever begin
      @(posedge go);
      repeat (n) begin
        #32 chain_clk = 1'b1;
        #32 chain_clk = 1'b0;
      end
    end
  end
  // Count the bytes handed over; only the newest is kept.
  always @(posedge clk) begin
    if (go) begin
      n_seen <= 8'h00;
    end else if (chain_data_valid) begin
      n_seen <= n_seen + 8'h01;
      last_byte <= chain_data;
    end
  end
endmodule : chain_partner
`default_nettype wire

// ### sim/test_comms_fault_monitor.sv
/*
  Self-checking bench for the fault monitor.
  Assumes the APB slave answers with pready and a chain partner model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_comms_fault_monitor;
  import fault_mon_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [10:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cmd_valid, cmd_crc_ok, nak, fwd_start, comms_fail, go;
  logic spi_byte_valid, chain_clk, chain_data_valid, meas_wr;
  logic sleep, scan_enable, wake, chain_reply;
  logic [5:0] cmd_code;
  logic [7:0] spi_byte, chain_data, last_byte, n_seen;
  logic [3:0] meas_idx, n;
  logic [15:0] meas_data;
  int n_fail = 0;
  int n_checks = 0;
  // A short watchdog tick keeps the expiry scenario brief.
  comms_fault_monitor #(.WDOG_TICK(4)) u_dut (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_crc_ok(cmd_crc_ok),
    .nak(nak), .fwd_start(fwd_start), .chain_reply(chain_reply),
    .comms_fail(comms_fail), .spi_byte_valid(spi_byte_valid),
    .spi_byte(spi_byte), .chain_clk(chain_clk), .chain_data(chain_data),
    .chain_data_valid(chain_data_valid), .meas_wr(meas_wr),
    .meas_idx(meas_idx), .meas_data(meas_data), .wake(wake),
    .sleep(sleep), .scan_enable(scan_enable));
  chain_partner u_chain (.clk(clk), .go(go), .n(n), .chain_data(chain_data),
    .chain_data_valid(chain_data_valid), .chain_clk(chain_clk),
    .last_byte(last_byte), .n_seen(n_seen));
  // Core clock at 250 MHz.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string name, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [10:0] a, input int d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic flag(input int b, input logic e);
    apb(1'b0, 11'h000, 0);
    chk("status flag", rd[b], e);
  endtask : flag
  task automatic cmd(input logic [5:0] c, input logic ok);
    @(posedge clk);
    cmd_valid <= 1'b1; cmd_code <= c; cmd_crc_ok <= ok;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask : cmd
  task automatic pops(input logic [3:0] k);
    n <= k;
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (300) @(posedge clk);
  endtask : pops
  task automatic final_report();
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, 11'h008, 0);
    chk("wdog period", rd, 32'h10);
    apb(1'b1, 11'h008, 0);
    apb(1'b0, 11'h400, 0);
    chk("reserved page", err, 1'b1);
    apb(1'b0, 11'h010, 0);
    chk("page0 hole", err, 1'b1);
    @(posedge clk) {meas_wr, meas_idx, meas_data} <= {5'h13, 16'habcd};
    @(posedge clk) meas_wr <= 1'b0;
    apb(1'b0, 11'h10c, 0);
    chk("result reg", rd, 32'habcd);
  endtask : t_regs
  task automatic t_cmds();
    cmd(CMD_SCAN_VOLT, 1'b0);
    #1 chk("nak", nak, 1'b1);
    flag(ST_CRC, 1'b1);
    apb(1'b1, 11'h000, 32'h7f);
    flag(ST_CRC, 1'b0);
    cmd(CMD_SCAN_VOLT, 1'b1);
    cmd(CMD_SCAN_TEMP, 1'b1);
    cmd(CMD_MEASURE, 1'b1);
    cmd(CMD_SCAN_MUX, 1'b1);
    apb(1'b1, 11'h304, 0);
    apb(1'b0, 11'h004, 0);
    chk("scan count", rd, 32'h0302);
  endtask : t_cmds
  task automatic t_timeout();
    int cnt;
    @(posedge clk) fwd_start <= 1'b1;
    @(posedge clk) fwd_start <= 1'b0;
    for (cnt = 1; comms_fail !== 1'b1 && cnt < 600; cnt++) @(posedge clk);
    chk("reply wait", cnt inside {[495:505]}, 1'b1);
    flag(ST_COMMS_FAIL, 1'b1);
    // A reply well inside the window must cancel the pending failure.
    apb(1'b1, 11'h000, 32'h7f);
    @(posedge clk) fwd_start <= 1'b1;
    @(posedge clk) fwd_start <= 1'b0;
    repeat (100) @(posedge clk);
    chain_reply <= 1'b1;
    @(posedge clk) chain_reply <= 1'b0;
    repeat (500) @(posedge clk);
    flag(ST_COMMS_FAIL, 1'b0);
  endtask : t_timeout
  task automatic t_fifo();
    for (int i = 0; i < 9; i++) begin
      @(posedge clk) {spi_byte_valid, spi_byte} <= {1'b1, 8'h10 + 8'(i)};
    end
    @(posedge clk) spi_byte_valid <= 1'b0;
    flag(ST_OVERRUN, 1'b1);
    pops(4'd8);
    chk("pop count", n_seen, 8'd8);
    chk("last byte", last_byte, 8'h17);
    flag(ST_BUF_FAULT, 1'b0);
    flag(ST_UNDERRUN, 1'b0);
    pops(4'd1);
    flag(ST_UNDERRUN, 1'b1);
  endtask : t_fifo
  task automatic t_csum();
    apb(1'b1, 11'h200, 32'h1234);
    apb(1'b1, 11'h314, 0);
    repeat (20) @(posedge clk);
    @(posedge clk) meas_wr <= 1'b1;
    @(posedge clk) meas_wr <= 1'b0;
    cmd(CMD_CHECK_CSUM, 1'b1);
    repeat (20) @(posedge clk);
    flag(ST_CSUM, 1'b0);
    apb(1'b1, 11'h200, 32'h4321);
    cmd(CMD_CHECK_CSUM, 1'b1);
    repeat (20) @(posedge clk);
    flag(ST_CSUM, 1'b1);
  endtask : t_csum
  task automatic t_wdog();
    apb(1'b1, 11'h008, 1);
    for (int i = 0; sleep !== 1'b1 && i < 100; i++) @(posedge clk);
    chk("sleep", sleep, 1'b1);
    chk("scan enable", scan_enable, 1'b0);
    flag(ST_WDOG, 1'b1);
    cmd(CMD_SCAN_VOLT, 1'b1);
    apb(1'b0, 11'h004, 0);
    chk("count asleep", rd, 32'h0302);
    // Disarm first, so the flag seen after wake-up is the kept one.
    apb(1'b1, 11'h008, 0);
    @(posedge clk) wake <= 1'b1;
    repeat (4) @(posedge clk);
    chk("awake", sleep, 1'b0);
    chk("scan resumed", scan_enable, 1'b1);
    flag(ST_WDOG, 1'b1);
  endtask : t_wdog
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {cmd_valid, cmd_code, cmd_crc_ok, fwd_start, go, n, wake} = '0;
    chain_reply = 1'b0;
    {spi_byte_valid, spi_byte, meas_wr, meas_idx, meas_data} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_cmds();
    t_timeout();
    t_fifo();
    t_csum();
    t_wdog();
    final_report();
  end
  // A hang ends the run as a failure.
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule : test_comms_fault_monitor
`default_nettype wire
